// File: verilog/lbs_drive.sv
// Purpose: APB registers and waveform sequencing for a multiplexed LCD.
// Assumes: One 50 MHz clock, synchronous active-low reset.
// Notes: Levels are codes for the analog selector outside.
//
// Contract
// RQ1: Four backplane outputs follow the drive mode.
// RQ2: In 1:3, backplane three copies backplane one.
// RQ3: In 1:2, pairs zero/two and one/three match.
// RQ4: Static mode drives all backplanes identically.
// RQ5: Eighteen segments from slot timing and data.
// RQ6: Third bias uses both taps; half only mid.
// RQ7: Control register sets drive and bias configuration.
// RQ8: 1:2 accepts half and third bias.
// RQ9: 1:3 and 1:4 also accept half bias.
// RQ10: Mode code picks number of active backplanes.
// RQ11: Host clears display enable before power off.
// RQ12: After reset stay powered down until enabled.
// RQ13: Reset gives 1:4, third bias, outputs grounded.
// RQ14: Invert on alternate frames or lines.
// RQ15: Step slots, wrap after last active backplane.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "lbs_defs.svh"

module lbs_drive #(
	parameter int NUM_SEG     = `LBS_NSEG,
	parameter int SLOT_CYCLES = `LBS_SLOT_CYCLES
) (
	input  wire logic                                  clk,
	input  wire logic                                  reset_n,
	input  wire lbs_pkg::lbs_apb_req_t                 apb_req,
	output lbs_pkg::lbs_apb_rsp_t                      apb_rsp,
	output lbs_pkg::lbs_level_t                        backplane_out_0,
	output lbs_pkg::lbs_level_t                        backplane_out_1,
	output lbs_pkg::lbs_level_t                        backplane_out_2,
	output lbs_pkg::lbs_level_t                        backplane_out_3,
	output lbs_pkg::lbs_level_t [NUM_SEG-1:0]          segment_out
);

	// Refuse sizes that the data words or the divider cannot hold.
	if (NUM_SEG < 1 || NUM_SEG > 32 || SLOT_CYCLES < 2 || SLOT_CYCLES > 65535) begin : g_chk
		$error("lbs_drive: unsupported NUM_SEG or SLOT_CYCLES");
	end

	// Width of the slot divider.
	localparam int DW = 16;
	// Divider value that ends a slot.
	localparam logic [DW-1:0] DIV_LAST = DW'(SLOT_CYCLES - 1);

	// All state of the block, outputs included.
	typedef struct packed {
		lbs_pkg::lbs_pwr_t                 pwr;
		logic                              de;
		logic                              inversion_select;
		lbs_pkg::lbs_bias_t                bias;
		lbs_pkg::lbs_mux_t                 mux;
		logic [3:0][NUM_SEG-1:0]           data;
		logic [DW-1:0]                     div;
		logic [1:0]                        slot;
		logic                              pol;
		lbs_pkg::lbs_level_t [3:0]         bp;
		lbs_pkg::lbs_level_t [NUM_SEG-1:0] seg;
		lbs_pkg::lbs_apb_rsp_t             rsp;
	} lbs_state_t;

	lbs_state_t s_r;   // Registered state.
	lbs_state_t s_nxt; // Next state.
	logic       setup; // APB setup cycle.
	logic       wr;    // Write taken at this edge.
	logic       tick;  // One-cycle slot enable from the divider.
	logic       frame_end; // Tick in the last active slot.

	// Slot of backplane k; shared outputs sit on the same slot.
	function automatic logic [1:0] bp_slot(lbs_pkg::lbs_mux_t m, int k);
		logic [1:0] kk;
		kk = 2'(k);
		unique case (m)
			lbs_pkg::MUX_STATIC: bp_slot = 2'h0; // RQ4
			lbs_pkg::MUX_2:      bp_slot = {1'b0, kk[0]}; // RQ3
			lbs_pkg::MUX_3:      bp_slot = (kk == 2'h3) ? 2'h1 : kk; // RQ2
			lbs_pkg::MUX_4:      bp_slot = kk;
		endcase
	endfunction

	// Backplane level: selected one swings full, others sit at a tap.
	function automatic lbs_pkg::lbs_level_t bp_level(lbs_state_t s, logic sel);
		if (sel || s.mux == lbs_pkg::MUX_STATIC) begin
			bp_level = s.pol ? lbs_pkg::LV_GND : lbs_pkg::LV_VLCD;
		end else if (s.bias == lbs_pkg::BIAS_HALF) begin
			bp_level = lbs_pkg::LV_HALF; // RQ6
		end else begin
			bp_level = s.pol ? lbs_pkg::LV_TWO_THIRD : lbs_pkg::LV_THIRD; // RQ6
		end
	endfunction

	// Segment level: on opposes the selected backplane, off stays near it.
	function automatic lbs_pkg::lbs_level_t seg_level(lbs_state_t s, logic on);
		if (on) begin
			seg_level = s.pol ? lbs_pkg::LV_VLCD : lbs_pkg::LV_GND;
		end else if (s.mux == lbs_pkg::MUX_STATIC || s.bias == lbs_pkg::BIAS_HALF) begin
			seg_level = s.pol ? lbs_pkg::LV_GND : lbs_pkg::LV_VLCD;
		end else begin
			seg_level = s.pol ? lbs_pkg::LV_THIRD : lbs_pkg::LV_TWO_THIRD; // RQ6
		end
	endfunction

	assign setup     = apb_req.psel && !apb_req.penable;
	assign wr        = apb_req.psel && apb_req.penable && apb_req.pwrite
	                   && s_r.rsp.pready && !s_r.rsp.pslverr;
	assign tick      = (s_r.pwr == lbs_pkg::PWR_RUN) && (s_r.div == DIV_LAST);
	assign frame_end = tick && (s_r.slot >= 2'(s_r.mux)); // RQ15

	// Next state: bus slave, power, slot sequencer and output levels.
	always_comb begin
		s_nxt = s_r;
		s_nxt.rsp.pready  = 1'b0;
		s_nxt.rsp.pslverr = 1'b0;
		// Setup cycle: decode and answer in the first access cycle.
		if (setup) begin
			s_nxt.rsp.pready = 1'b1;
			s_nxt.rsp.prdata = 32'h00000000;
			if (apb_req.paddr == `LBS_OFS_CTRL) begin
				s_nxt.rsp.prdata[`LBS_CTRL_DE]       = s_r.de;
				s_nxt.rsp.prdata[`LBS_CTRL_INV]      = s_r.inversion_select;
				s_nxt.rsp.prdata[`LBS_CTRL_BIAS]     = s_r.bias;
				s_nxt.rsp.prdata[`LBS_CTRL_MUX +: 2] = s_r.mux;
			end else if (apb_req.paddr == `LBS_OFS_STAT) begin
				s_nxt.rsp.prdata[3:0] = {s_r.pol, s_r.slot, s_r.pwr == lbs_pkg::PWR_RUN};
			end else if (apb_req.paddr >= `LBS_OFS_DATA0 && apb_req.paddr <= `LBS_OFS_DATA3
			             && apb_req.paddr[1:0] == 2'h0) begin
				s_nxt.rsp.prdata[NUM_SEG-1:0] = s_r.data[2'(apb_req.paddr[11:2] - 10'h002)];
			end else begin
				s_nxt.rsp.pslverr = 1'b1; // Unmapped address.
			end
		end
		// Access edge: a write takes effect here and nowhere else.
		if (wr) begin
			if (apb_req.paddr == `LBS_OFS_CTRL) begin
				s_nxt.de   = apb_req.pwdata[`LBS_CTRL_DE]; // RQ7
				s_nxt.inversion_select  = apb_req.pwdata[`LBS_CTRL_INV];
				s_nxt.bias = lbs_pkg::lbs_bias_t'(apb_req.pwdata[`LBS_CTRL_BIAS]); // RQ8 RQ9
				s_nxt.mux  = lbs_pkg::lbs_mux_t'(apb_req.pwdata[`LBS_CTRL_MUX +: 2]); // RQ10
			end else if (apb_req.paddr != `LBS_OFS_STAT) begin
				s_nxt.data[2'(apb_req.paddr[11:2] - 10'h002)] = apb_req.pwdata[NUM_SEG-1:0];
			end
		end
		// Power state: sequencer is held still while powered down.
		unique case (s_r.pwr)
			lbs_pkg::PWR_DOWN: begin
				s_nxt.div  = '0;
				s_nxt.slot = 2'h0;
				s_nxt.pol  = 1'b0;
				if (s_r.de) begin
					s_nxt.pwr = lbs_pkg::PWR_RUN; // RQ12
				end
			end
			lbs_pkg::PWR_RUN: begin
				if (!s_r.de) begin
					s_nxt.pwr = lbs_pkg::PWR_DOWN; // RQ12
				end else if (tick) begin
					s_nxt.div  = '0;
					s_nxt.slot = frame_end ? 2'h0 : s_r.slot + 2'h1; // RQ15
					// Line inversion flips every slot, frame inversion per frame.
					if (s_r.inversion_select || frame_end) begin
						s_nxt.pol = !s_r.pol; // RQ14
					end
				end else begin
					s_nxt.div = s_r.div + DW'(1);
				end
			end
		endcase
		// Output levels from the present slot; ground while powered down.
		for (int k = 0; k < 4; k++) begin
			if (s_r.pwr == lbs_pkg::PWR_DOWN) begin
				s_nxt.bp[k] = lbs_pkg::LV_GND; // RQ12
			end else begin
				s_nxt.bp[k] = bp_level(s_r, bp_slot(s_r.mux, k) == s_r.slot); // RQ1
			end
		end
		for (int i = 0; i < NUM_SEG; i++) begin
			if (s_r.pwr == lbs_pkg::PWR_DOWN) begin
				s_nxt.seg[i] = lbs_pkg::LV_GND;
			end else begin
				s_nxt.seg[i] = seg_level(s_r, s_r.data[s_r.slot][i]); // RQ5
			end
		end
	end

	// State register with reset to 1:4, third bias, display off.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_r      <= '0; // RQ13
			s_r.mux  <= lbs_pkg::lbs_mux_t'(2'(`LBS_CTRL_RST >> `LBS_CTRL_MUX)); // RQ13
			s_r.bias <= lbs_pkg::BIAS_THIRD;
			s_r.pwr  <= lbs_pkg::PWR_DOWN;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign apb_rsp         = s_r.rsp;
	assign backplane_out_0 = s_r.bp[0];
	assign backplane_out_1 = s_r.bp[1];
	assign backplane_out_2 = s_r.bp[2];
	assign backplane_out_3 = s_r.bp[3];
	assign segment_out     = s_r.seg;

	// Checks on the outputs and the sequencer.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// Backplane three follows backplane one in 1:3.
	property p_backplane_out_3_copy;
		(s_r.pwr == lbs_pkg::PWR_RUN && s_r.mux == lbs_pkg::MUX_3) |=> (s_r.bp[3] == s_r.bp[1]);
	endproperty
	a_backplane_out_3_copy: assert property (p_backplane_out_3_copy) else $error("backplane_out_3 differs from backplane_out_1"); // RQ2

	// Pairs match in 1:2.
	property p_pairs;
		(s_r.mux == lbs_pkg::MUX_2) |=> (s_r.bp[0] == s_r.bp[2] && s_r.bp[1] == s_r.bp[3]);
	endproperty
	a_pairs: assert property (p_pairs) else $error("1:2 pairs differ"); // RQ3

	// All four equal in static mode, full swing only.
	property p_static;
		(s_r.pwr == lbs_pkg::PWR_RUN && s_r.mux == lbs_pkg::MUX_STATIC) |=>
			(s_r.bp[0] == s_r.bp[1] && s_r.bp[2] == s_r.bp[3] && s_r.bp[0] == s_r.bp[3]
			 && (s_r.bp[0] == lbs_pkg::LV_GND || s_r.bp[0] == lbs_pkg::LV_VLCD));
	endproperty
	a_static: assert property (p_static) else $error("static backplanes differ"); // RQ4

	// Half bias never uses the third taps.
	property p_half;
		(s_r.pwr == lbs_pkg::PWR_RUN && s_r.bias == lbs_pkg::BIAS_HALF) |=>
			(s_r.bp[0] != lbs_pkg::LV_THIRD && s_r.bp[0] != lbs_pkg::LV_TWO_THIRD);
	endproperty
	a_half: assert property (p_half) else $error("third tap in half bias"); // RQ6

	// An on segment takes the level opposite to the selected backplane.
	property p_seg_on;
		(s_r.pwr == lbs_pkg::PWR_RUN && s_r.data[s_r.slot][0]) |=>
			(s_r.seg[0] == ($past(s_r.pol) ? lbs_pkg::LV_VLCD : lbs_pkg::LV_GND));
	endproperty
	a_seg_on: assert property (p_seg_on) else $error("on segment level wrong"); // RQ5

	// Powered down: outputs grounded two edges later, start only on enable.
	property p_down;
		(s_r.pwr == lbs_pkg::PWR_DOWN && !s_r.de) |=> ##1
			(s_r.bp[0] == lbs_pkg::LV_GND && s_r.seg[0] == lbs_pkg::LV_GND);
	endproperty
	a_down: assert property (p_down) else $error("output not grounded"); // RQ12

	// Enable starts the sequencer at the next edge.
	property p_start;
		(s_r.pwr == lbs_pkg::PWR_DOWN && s_r.de) |=> (s_r.pwr == lbs_pkg::PWR_RUN);
	endproperty
	a_start: assert property (p_start) else $error("enable did not start"); // RQ12

	// Reset values.
	property p_reset;
		@(posedge clk) disable iff (1'b0) !reset_n |=>
			(s_r.mux == lbs_pkg::MUX_4 && s_r.bias == lbs_pkg::BIAS_THIRD && !s_r.de
			 && s_r.bp[1] == lbs_pkg::LV_GND);
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong"); // RQ13

	// Frame inversion holds polarity inside a frame.
	property p_frame_inv;
		(tick && !frame_end && !s_r.inversion_select && s_r.de) |=> $stable(s_r.pol);
	endproperty
	a_frame_inv: assert property (p_frame_inv) else $error("polarity flipped mid-frame"); // RQ14

	// Wrap to the first slot after the last active one.
	property p_wrap;
		(frame_end && s_r.de) |=> (s_r.slot == 2'h0 && s_r.div == '0);
	endproperty
	a_wrap: assert property (p_wrap) else $error("slot did not wrap"); // RQ15

	// Third bias puts an unselected backplane on one of the third taps.
	property p_third_taps;
		(s_r.pwr == lbs_pkg::PWR_RUN && s_r.bias == lbs_pkg::BIAS_THIRD
		 && s_r.mux != lbs_pkg::MUX_STATIC && s_r.slot != 2'h0) |=>
			(s_r.bp[0] inside {lbs_pkg::LV_THIRD, lbs_pkg::LV_TWO_THIRD});
	endproperty
	a_third_taps: assert property (p_third_taps) else $error("third tap missing"); // RQ6

	// Half bias and static mode keep segment zero on a rail.
	property p_half_seg;
		(s_r.pwr == lbs_pkg::PWR_RUN
		 && (s_r.bias == lbs_pkg::BIAS_HALF || s_r.mux == lbs_pkg::MUX_STATIC)) |=>
			(s_r.seg[0] inside {lbs_pkg::LV_GND, lbs_pkg::LV_VLCD});
	endproperty
	a_half_seg: assert property (p_half_seg) else $error("segment on a bias tap"); // RQ6

	// A control write lands its enable, bias and drive fields together.
	property p_ctrl_write;
		(wr && apb_req.paddr == `LBS_OFS_CTRL) |=>
			(s_r.de == $past(apb_req.pwdata[`LBS_CTRL_DE])
			 && s_r.bias == $past(apb_req.pwdata[`LBS_CTRL_BIAS])
			 && s_r.mux == $past(apb_req.pwdata[`LBS_CTRL_MUX +: 2]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // RQ7

	// Setup is answered in the next cycle.
	property p_ready;
		setup |=> s_r.rsp.pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready late"); // RQ7

endmodule

// File: verilog/lbs_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by its bare name.
// Notes: Definitions only.
`ifndef LBS_DEFS_SVH
`define LBS_DEFS_SVH
`define LBS_NSEG        18
`define LBS_SLOT_CYCLES 16
`define LBS_OFS_CTRL    12'h000
`define LBS_OFS_STAT    12'h004
`define LBS_OFS_DATA0   12'h008
`define LBS_OFS_DATA3   12'h014
`define LBS_CTRL_DE     0
`define LBS_CTRL_INV    1
`define LBS_CTRL_BIAS   2
`define LBS_CTRL_MUX    4
`define LBS_CTRL_RST    32'h00000030
`endif

// File: verilog/lbs_pkg.sv
// Purpose: Types shared by the LCD backplane and segment drive block.
// Assumes: Nothing.
// Notes: Used by scoped name only.
package lbs_pkg;
	// Drive level on one electrode.
	typedef enum logic [2:0] {LV_GND, LV_THIRD, LV_HALF, LV_TWO_THIRD, LV_VLCD} lbs_level_t;
	// Multiplex mode; the code equals the last active slot.
	typedef enum logic [1:0] {MUX_STATIC, MUX_2, MUX_3, MUX_4} lbs_mux_t;
	// Bias mode.
	typedef enum logic {BIAS_THIRD, BIAS_HALF} lbs_bias_t;
	// Power state.
	typedef enum logic {PWR_DOWN, PWR_RUN} lbs_pwr_t;
	// APB request from the master.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} lbs_apb_req_t;
	// APB answer to the master.
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} lbs_apb_rsp_t;
endpackage

// File: test/lbs_panel.sv
// Purpose: Passive model of the LCD panel electrodes on the drive outputs.
// Assumes: Levels arrive as selector codes from the drive block.
// Notes: Reports which backplanes currently see a full-swing level.
`timescale 1ns/1ns

module lbs_panel (
	input  wire lbs_pkg::lbs_level_t backplane_out_0,
	input  wire lbs_pkg::lbs_level_t backplane_out_1,
	input  wire lbs_pkg::lbs_level_t backplane_out_2,
	input  wire lbs_pkg::lbs_level_t backplane_out_3,
	output logic [3:0]               sel_mask
);
	// A row is addressed while its electrode sits at a rail, never at a bias tap.
	always_comb begin
		sel_mask[0] = backplane_out_0 inside {lbs_pkg::LV_GND, lbs_pkg::LV_VLCD};
		sel_mask[1] = backplane_out_1 inside {lbs_pkg::LV_GND, lbs_pkg::LV_VLCD};
		sel_mask[2] = backplane_out_2 inside {lbs_pkg::LV_GND, lbs_pkg::LV_VLCD};
		sel_mask[3] = backplane_out_3 inside {lbs_pkg::LV_GND, lbs_pkg::LV_VLCD};
	end
endmodule

// File: test/lbs_drive_tb.sv
// Purpose: Self-checking bench for the LCD backplane and segment drive.
// Assumes: Slots shortened to three clocks; APB master drives on rising edges.
// Notes: Every mode, bias and inversion choice runs with random display data.
`timescale 1ns/1ns
`include "lbs_defs.svh"

module lbs_drive_tb;
	localparam int S = 3;                     // Shortened slot length in clocks.
	logic                           clk;      // Bench clock.
	logic                           reset_n;  // Synchronous active-low reset.
	lbs_pkg::lbs_apb_req_t          req;      // APB request.
	lbs_pkg::lbs_apb_rsp_t          rsp;      // APB answer.
	lbs_pkg::lbs_level_t            bp0, bp1, bp2, bp3;
	lbs_pkg::lbs_level_t [17:0]     seg;      // Segment levels.
	logic [3:0]                     sel_mask; // Rows at full swing, seen by the panel.
	int                             fails, checked, c, s, k;
	logic [31:0]                    seed, rd;
	logic                           err, half, line;
	logic [1:0]                     mode;
	logic [17:0]                    dat [4];  // Display data per slot.

	lbs_drive #(.NUM_SEG(18), .SLOT_CYCLES(S)) lbs_drive_i (.clk(clk), .reset_n(reset_n),
		.apb_req(req), .apb_rsp(rsp), .backplane_out_0(bp0), .backplane_out_1(bp1),
		.backplane_out_2(bp2), .backplane_out_3(bp3), .segment_out(seg));
	lbs_panel lbs_panel_i (.backplane_out_0(bp0), .backplane_out_1(bp1),
		.backplane_out_2(bp2), .backplane_out_3(bp3), .sel_mask(sel_mask));

	// The clock toggles every half period of 10 ns.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Compares a seen value against the expected one.
	task automatic check(input string what, input logic [69:0] seen, input logic [69:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic wrap_up;
		if (fails == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Steps the xorshift generator.
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	// Gathers everything the panel sees into one vector.
	function automatic logic [69:0] outs();
		return {sel_mask, bp3, bp2, bp1, bp0, seg};
	endfunction

	// Works out the expected electrode levels k samples after the outputs start.
	function automatic logic [69:0] model(input int k);
		int n, slot, lg;
		logic pol;
		logic [3:0] m;
		lbs_pkg::lbs_level_t bp [4];
		lbs_pkg::lbs_level_t [17:0] sg;
		n = mode + 1;
		slot = (k / S) % n;
		pol = line ? (k / S) % 2 : (k / (S * n)) % 2;
		for (int i = 0; i < 4; i++) begin
			lg = (mode == 2'h0) ? 0 : (mode == 2'h1) ? i % 2 : (mode == 2'h2 && i == 3) ? 1 : i;
			m[i] = (lg == slot);
			bp[i] = m[i] ? (pol ? lbs_pkg::LV_GND : lbs_pkg::LV_VLCD) : half ? lbs_pkg::LV_HALF
				: (pol ? lbs_pkg::LV_TWO_THIRD : lbs_pkg::LV_THIRD);
		end
		for (int j = 0; j < 18; j++) begin
			sg[j] = dat[slot][j] ? (pol ? lbs_pkg::LV_VLCD : lbs_pkg::LV_GND)
				: (mode == 2'h0 || half) ? (pol ? lbs_pkg::LV_GND : lbs_pkg::LV_VLCD)
				: (pol ? lbs_pkg::LV_THIRD : lbs_pkg::LV_TWO_THIRD);
		end
		return {m, bp[3], bp[2], bp[1], bp[0], sg};
	endfunction

	// One APB transfer; it returns at the edge where pready was sampled high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int i;
		@(posedge clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= wd;
		@(posedge clk);
		req.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (rsp.pready !== 1'b1 && i < 20);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (rsp.pready !== 1'b1) begin
			fails++;
			wrap_up();
		end
	endtask

	// Holds reset for 16 clocks, then checks the grounded outputs and reset registers.
	task automatic rst_seq;
		reset_n <= 1'b0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		check("outputs after reset", outs(), {4'hF, 66'h0});
		apb(1'b0, `LBS_OFS_CTRL, 32'h0);
		check("control after reset", rd, `LBS_CTRL_RST);
		apb(1'b0, `LBS_OFS_STAT, 32'h0);
		check("running after reset", rd[0], 1'b0);
	endtask

	// Main sequence: reset, idle, refused access, then every drive configuration.
	initial begin
		reset_n = 1'b0;
		req = '0;
		seed = 32'h00009F2C;
		fails = 0;
		checked = 0;
		@(posedge clk);
		rst_seq();
		repeat (20) @(posedge clk);
		check("idle without enable", outs(), {4'hF, 66'h0});
		apb(1'b0, 12'h020, 32'h0);
		check("unmapped error", err, 1'b1);
		for (c = 0; c < 16; c++) begin
			mode = c[1:0];
			half = c[2];
			line = c[3];
			// Random data per slot; bits above the segment count read back as zero.
			for (s = 0; s < 4; s++) begin
				seed = xs(seed);
				dat[s] = seed[17:0];
				apb(1'b1, `LBS_OFS_DATA0 + 12'(4 * s), seed);
				apb(1'b0, `LBS_OFS_DATA0 + 12'(4 * s), 32'h0);
				check("display data", rd, {14'h0, seed[17:0]});
			end
			apb(1'b1, `LBS_OFS_CTRL, {26'h0, mode, 1'b0, half, line, 1'b1});
			repeat (2) @(posedge clk);
			for (k = 0; k < 12 * S; k++) begin
				@(posedge clk);
				check("drive levels", outs(), model(k));
			end
			// The status word reports the running sequencer and no stray bits.
			apb(1'b0, `LBS_OFS_STAT, 32'h0);
			check("running while enabled", rd[0], 1'b1);
			check("status spare bits", rd[31:4], 28'h0);
			// The host disables the display before any power removal.
			apb(1'b1, `LBS_OFS_CTRL, {26'h0, mode, 1'b0, half, line, 1'b0});
			repeat (3) @(posedge clk);
			check("outputs when disabled", outs(), {4'hF, 66'h0});
		end
		apb(1'b1, `LBS_OFS_CTRL, 32'h00000025);
		repeat (10) @(posedge clk);
		rst_seq();
		wrap_up();
	end
endmodule
